/* hw/clock_watchdog_current_config.sv */
/*
  Clock reference, host watchdog, spread spectrum and supply current cap
  configuration registers behind an AXI4-Lite slave, with the watchdog.
  Assumes all inputs are synchronous to clock_in; the I2C target elsewhere
  in the device gives one pulse on i2c_kick_in for each kick transaction.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bits 7-5 pick reference rate, 8 kHz doubling.
// - Bit 4 enables host watchdog kick monitoring.
// - Bits 3-2 set kick interval per path.
// - Bit 1 picks kick path: I2C or GPIO.
// - Bit 0: report only, or latch with Hi-Z.
// - Bit 30 disables spread spectrum, resets to one.
// - Bits 25-22 pick the supply current cap.
// - Bit 21 enforces the cap; else no limit.
// - Peripheral register decodes at index AAh.
// - Reference clock used only when input enabled.
// - Two-bit clock source field selects core clock.
module clock_watchdog_current_config
  import clock_watchdog_pkg::*;
#(
  parameter int UNIT_CYCLES = MS_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite slave.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Kick sources.
  input  wire logic        i2c_kick_in,
  input  wire logic        gpio_kick_in,
  // Configuration outputs.
  output logic [2:0]       ref_clock_rate_sel_out,
  output logic [10:0]      ref_clock_khz_out,
  output logic             ref_clock_input_on_out,
  output logic [1:0]       clock_source_out,
  output logic             spectrum_spreading_out,
  output logic             current_limit_on_out,
  output logic [13:0]      current_cap_ma_out,
  // Watchdog results.
  output logic             watchdog_fault_out,
  output logic             fault_latched_out,
  output logic             power_stage_hiz_out,
  output logic             irq_out
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [31:0]          setup_two_reg;
  logic [31:0]          peri_one_reg;
  logic [IRQ_WIDTH-1:0] irq_status_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic                 fault_latched_reg;
  logic                 gpio_kick_d_reg;

  // ----------------------------------------
  // Write channel state
  // ----------------------------------------
  logic        aw_have_reg;
  logic [11:0] aw_addr_reg;
  logic        w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic        write_hit;
  logic [31:0] write_mask;
  logic        do_read;
  logic        read_hit;
  logic [31:0] read_value;
  logic        status_read;
  logic        latch_clear;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign do_write      = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      write_mask[i*8 +: 8] = {8{w_strb_reg[i]}};
    end
  end

  always_comb begin
    unique case (aw_addr_reg & 12'hffc)
      SETUP_TWO_ADDR, PERI_ONE_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR,
      WDT_CTRL_ADDR, WDT_STATUS_ADDR: write_hit = 1'b1;
      default:                        write_hit = 1'b0;
    endcase
  end

  // Address and data are taken separately, in either order.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 12'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      setup_two_reg <= SETUP_TWO_RESET;
    end else if (do_write && (aw_addr_reg & 12'hffc) == SETUP_TWO_ADDR) begin
      setup_two_reg <= ((setup_two_reg & ~write_mask) |
                        (w_data_reg & write_mask)) & SETUP_TWO_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      peri_one_reg <= PERI_ONE_RESET;
    end else if (do_write && (aw_addr_reg & 12'hffc) == PERI_ONE_ADDR) begin
      peri_one_reg <= ((peri_one_reg & ~write_mask) |
                       (w_data_reg & write_mask)) & PERI_ONE_MASK;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_mask_reg <= '0;
    end else if (do_write && (aw_addr_reg & 12'hffc) == IRQ_MASK_ADDR &&
                 w_strb_reg[0]) begin
      irq_mask_reg <= w_data_reg[IRQ_WIDTH-1:0];
    end
  end

  assign latch_clear = do_write && (aw_addr_reg & 12'hffc) == WDT_CTRL_ADDR &&
                       w_strb_reg[0] && w_data_reg[LATCH_CLEAR_BIT];

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  logic        wdt_on;
  logic        gpio_path;
  logic        kick;
  logic        timeout;
  logic [13:0] limit_ms;

  assign wdt_on    = setup_two_reg[WDT_ON_BIT];
  assign gpio_path = setup_two_reg[KICK_PATH_BIT];
  assign limit_ms  = kick_interval_ms(gpio_path,
                       setup_two_reg[INTERVAL_LSB +: 2]);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gpio_kick_d_reg <= 1'b0;
    end else begin
      gpio_kick_d_reg <= gpio_kick_in;
    end
  end

  // A kick counts only on the selected path; the host must keep pace.
  assign kick = wdt_on && (gpio_path ? (gpio_kick_in && !gpio_kick_d_reg)
                                     : i2c_kick_in);

  kick_interval_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) timer_inst (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .run_in      (wdt_on),
    .kick_in     (kick),
    .limit_ms_in (limit_ms),
    .timeout_out (timeout)
  );

  // The latched fault holds the power stages off until software clears it.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fault_latched_reg <= 1'b0;
    end else if (timeout && setup_two_reg[TIMEOUT_ACT_BIT]) begin
      fault_latched_reg <= 1'b1;
    end else if (latch_clear) begin
      fault_latched_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      watchdog_fault_out  <= 1'b0;
      power_stage_hiz_out <= 1'b0;
    end else begin
      watchdog_fault_out  <= timeout;
      power_stage_hiz_out <= fault_latched_reg ||
                             (timeout && setup_two_reg[TIMEOUT_ACT_BIT]);
    end
  end

  assign fault_latched_out = fault_latched_reg;

  // ----------------------------------------------------------------------
  // Interrupt status, cleared by reading it; a new event wins.
  // ----------------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irq_events;

  always_comb begin
    irq_events                  = '0;
    irq_events[IRQ_TIMEOUT_BIT] = timeout;
    irq_events[IRQ_KICK_BIT]    = kick;
    irq_events[IRQ_LATCH_BIT]   = timeout && setup_two_reg[TIMEOUT_ACT_BIT];
  end

  assign status_read = do_read &&
                       (s_axi_araddr & 12'hffc) == IRQ_STATUS_ADDR;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (status_read ? '0 : irq_status_reg) | irq_events;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((status_read ? '0 : irq_status_reg) | irq_events) &
                   irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    read_value = 32'h0;
    read_hit   = 1'b1;
    unique case (s_axi_araddr & 12'hffc)
      SETUP_TWO_ADDR:  read_value = setup_two_reg;
      PERI_ONE_ADDR:   read_value = peri_one_reg;
      IRQ_STATUS_ADDR: read_value = 32'(irq_status_reg);
      IRQ_MASK_ADDR:   read_value = 32'(irq_mask_reg);
      WDT_CTRL_ADDR:   read_value = 32'h0;
      WDT_STATUS_ADDR: read_value = {29'h0, wdt_on, watchdog_fault_out,
                                     fault_latched_reg};
      default:         read_hit   = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_value;
      s_axi_rresp  <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  logic [1:0] source_code;

  assign source_code = setup_two_reg[CLK_SOURCE_LSB +: 2];

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ref_clock_rate_sel_out <= 3'h0;
      ref_clock_khz_out      <= 11'h0;
      ref_clock_input_on_out <= 1'b0;
      clock_source_out       <= CLK_INTERNAL;
    end else begin
      ref_clock_rate_sel_out <= setup_two_reg[REF_RATE_LSB +: 3];
      ref_clock_khz_out      <= 11'(REF_BASE_KHZ) <<
                                setup_two_reg[REF_RATE_LSB +: 3];
      ref_clock_input_on_out <= setup_two_reg[REF_INPUT_ON_BIT];
      // The unusable code and an external source without the reference
      // input enabled both fall back to the internal oscillator.
      if (source_code == CLK_NONE ||
          (source_code == CLK_EXTERNAL &&
           !setup_two_reg[REF_INPUT_ON_BIT])) begin
        clock_source_out <= CLK_INTERNAL;
      end else begin
        clock_source_out <= source_code;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      spectrum_spreading_out <= 1'b0;
      current_limit_on_out   <= 1'b0;
      current_cap_ma_out     <= 14'h0;
    end else begin
      spectrum_spreading_out <= !peri_one_reg[SPREAD_OFF_BIT];
      current_limit_on_out   <= peri_one_reg[CUR_CAP_ON_BIT];
      current_cap_ma_out     <= peri_one_reg[CUR_CAP_ON_BIT] ?
                                current_cap_ma(peri_one_reg[CUR_CAP_LSB +: 4])
                                : 14'h0;
    end
  end

endmodule  // clock_watchdog_current_config

`default_nettype wire

/* hw/clock_watchdog_pkg.sv */
/*
  Constants of the clock, watchdog and current setup slice.
  Assumes one 25 MHz core clock and an AXI4-Lite register bus.
*/
package clock_watchdog_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] SETUP_TWO_INDEX  = 12'h0a8;
  localparam logic [11:0] PERI_ONE_INDEX   = 12'h0aa;
  localparam logic [11:0] SETUP_TWO_ADDR   = 12'(SETUP_TWO_INDEX * 4);
  localparam logic [11:0] PERI_ONE_ADDR    = 12'(PERI_ONE_INDEX * 4);
  localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h300;
  localparam logic [11:0] IRQ_MASK_ADDR    = 12'h304;
  localparam logic [11:0] WDT_CTRL_ADDR    = 12'h308;
  localparam logic [11:0] WDT_STATUS_ADDR  = 12'h30c;

  localparam logic [31:0] SETUP_TWO_RESET  = 32'h0000_0000;
  localparam logic [31:0] PERI_ONE_RESET   = 32'h4000_0000;
  localparam logic [31:0] SETUP_TWO_MASK   = 32'h0000_07ff;
  localparam logic [31:0] PERI_ONE_MASK    = 32'h43e0_0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int REF_RATE_LSB      = 5;
  localparam int WDT_ON_BIT        = 4;
  localparam int INTERVAL_LSB      = 2;
  localparam int KICK_PATH_BIT     = 1;
  localparam int TIMEOUT_ACT_BIT   = 0;
  localparam int REF_INPUT_ON_BIT  = 8;
  localparam int CLK_SOURCE_LSB    = 9;
  localparam int SPREAD_OFF_BIT    = 30;
  localparam int CUR_CAP_LSB       = 22;
  localparam int CUR_CAP_ON_BIT    = 21;

  localparam int IRQ_TIMEOUT_BIT   = 0;
  localparam int IRQ_KICK_BIT      = 1;
  localparam int IRQ_LATCH_BIT     = 2;
  localparam int IRQ_WIDTH         = 3;
  localparam int LATCH_CLEAR_BIT   = 0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS   = 40;
  localparam int MS_UNIT_NS        = 1000000;
  localparam int MS_CYCLES         = MS_UNIT_NS / CLOCK_PERIOD_NS;
  localparam int MS_COUNT_WIDTH    = 14;
  localparam int REF_BASE_KHZ      = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'b00,
    CLK_CRUDE    = 2'b01,
    CLK_NONE     = 2'b10,
    CLK_EXTERNAL = 2'b11
  } clock_source_e;

  // Allowed time between kicks in milliseconds.
  function automatic logic [13:0] kick_interval_ms(input logic gpio_path,
                                                   input logic [1:0] code);
    logic [13:0] base;
    base = 14'd0;
    unique case (code)
      2'b00: base = 14'd100;
      2'b01: base = 14'd200;
      2'b10: base = 14'd500;
      2'b11: base = 14'd1000;
    endcase
    kick_interval_ms = gpio_path ? base : 14'(base * 10);
  endfunction

  // Supply current cap in milliamperes.
  function automatic logic [13:0] current_cap_ma(input logic [3:0] code);
    current_cap_ma = 14'd0;
    unique case (code)
      4'h0: current_cap_ma = 14'd125;
      4'h1: current_cap_ma = 14'd250;
      4'h2: current_cap_ma = 14'd500;
      4'he: current_cap_ma = 14'd7000;
      4'hf: current_cap_ma = 14'd8000;
      default: current_cap_ma = 14'(14'd500 * ({10'h0, code} - 14'd1));
    endcase
  endfunction

endpackage

/* hw/kick_interval_timer.sv */
/*
  Millisecond interval timer for the host-serviced watchdog.
  Assumes kick_in is a one-cycle pulse synchronous to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none

module kick_interval_timer
  import clock_watchdog_pkg::*;
#(
  parameter int UNIT_CYCLES = MS_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        run_in,
  input  wire logic        kick_in,
  input  wire logic [13:0] limit_ms_in,
  output logic             timeout_out
);

  logic [31:0] prescale_reg;
  logic [13:0] elapsed_reg;
  logic        unit_done;

  assign unit_done = (prescale_reg == 32'(UNIT_CYCLES - 1));

  // ----------------------------------------
  // Count whole milliseconds since the last kick.
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !run_in || kick_in || timeout_out) begin
      prescale_reg <= 32'h0;
      elapsed_reg  <= 14'h0;
    end else if (unit_done) begin
      prescale_reg <= 32'h0;
      elapsed_reg  <= elapsed_reg + 14'h1;
    end else begin
      prescale_reg <= prescale_reg + 32'h1;
    end
  end

  // The timeout fires once the full interval has elapsed without a kick.
  assign timeout_out = run_in && !kick_in &&
                       (elapsed_reg >= limit_ms_in);

endmodule  // kick_interval_timer

`default_nettype wire

/* tb/clock_watchdog_current_config_chk.sv */
/*
  Port checker for the clock, watchdog and current setup slice.
  Assumes it is bound to every instance of the top module by port name.
*/
`timescale 1ns/1ps
`default_nettype none

module clock_watchdog_current_config_chk (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [2:0]  ref_clock_rate_sel_out,
  input wire logic [10:0] ref_clock_khz_out,
  input wire logic        ref_clock_input_on_out,
  input wire logic [1:0]  clock_source_out,
  input wire logic        current_limit_on_out,
  input wire logic [13:0] current_cap_ma_out,
  input wire logic        watchdog_fault_out
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bresp_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_write_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_rate_doubles:
    assert property ($past(rst_n_in) |-> ref_clock_khz_out
      == (11'h8 << ref_clock_rate_sel_out)) else $error("rate mismatch");
  a_source_legal:
    assert property (clock_source_out != 2'b10)
      else $error("clock source code two driven");
  a_external_gated:
    assert property (clock_source_out == 2'b11 |-> ref_clock_input_on_out)
      else $error("external clock without enable");
  a_cap_gated:
    assert property (!current_limit_on_out |-> current_cap_ma_out == 14'h0)
      else $error("cap applied while disabled");
  a_fault_pulse:
    assert property (watchdog_fault_out |=> !watchdog_fault_out)
      else $error("fault pulse too long");
endmodule  // clock_watchdog_current_config_chk

bind clock_watchdog_current_config clock_watchdog_current_config_chk
  chk_u (.*);

`default_nettype wire

/* tb/host_kicker.sv */
/*
  Host controller model that kicks the watchdog on the I2C or GPIO path.
  Assumes the bench sets the path and a kick period in core clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module host_kicker (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        path_in,
  input  wire logic [15:0] period_in,
  output logic             i2c_kick_out,
  output logic             gpio_kick_out
);
  logic [15:0] count_reg;
  logic        run;

  // A zero period keeps the host silent.
  assign run = period_in != 16'h0;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !run || count_reg >= period_in) begin
      count_reg <= 16'h0;
    end else begin
      count_reg <= count_reg + 16'h1;
    end
  end

  // One pulse per period on I2C, one rising edge per period on GPIO.
  always_ff @(posedge clock_in) begin
    i2c_kick_out  <= rst_n_in && run && !path_in && count_reg == 16'h1;
    gpio_kick_out <= rst_n_in && run && path_in && count_reg != 16'h0
                     && count_reg < 16'h8;
  end
endmodule  // host_kicker

`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the clock, watchdog and current setup slice.
  Assumes the package is compiled first and a one millisecond unit of 4.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import clock_watchdog_pkg::*;
;
  localparam logic [11:0] S2 = SETUP_TWO_ADDR;
  localparam logic [11:0] P1 = PERI_ONE_ADDR;
  typedef struct {
    logic [11:0] a; logic [31:0] d, rd; logic [10:0] khz;
    logic [1:0] src; logic [13:0] cap; logic spread;
  } row_s;
  row_s rows[15] = '{
    '{S2, 32'h0000_00e0, 32'h0000_00e0, 11'd1024, 2'd0, 14'd0, 1'b0},
    '{S2, 32'h0000_0760, 32'h0000_0760, 11'd64, 2'd3, 14'd0, 1'b0},
    '{S2, 32'h0000_0600, 32'h0000_0600, 11'd8, 2'd0, 14'd0, 1'b0},
    '{S2, 32'h0000_0500, 32'h0000_0500, 11'd8, 2'd0, 14'd0, 1'b0},
    '{S2, 32'h0000_0220, 32'h0000_0220, 11'd16, 2'd1, 14'd0, 1'b0},
    '{S2, 32'hffff_ffef, 32'h0000_07ef, 11'd1024, 2'd3, 14'd0, 1'b0},
    '{P1, 32'h0000_0000, 32'h0000_0000, 11'd1024, 2'd3, 14'd0, 1'b1},
    '{P1, 32'h0020_0000, 32'h0020_0000, 11'd1024, 2'd3, 14'd125, 1'b1},
    '{P1, 32'h40e0_0000, 32'h40e0_0000, 11'd1024, 2'd3, 14'd1000, 1'b0},
    '{P1, 32'h0360_0000, 32'h0360_0000, 11'd1024, 2'd3, 14'd6000, 1'b1},
    '{P1, 32'hffff_ffff, 32'h43e0_0000, 11'd1024, 2'd3, 14'd8000, 1'b0},
    '{P1, 32'h03c0_0000, 32'h03c0_0000, 11'd1024, 2'd3, 14'd0, 1'b1},
    '{P1, 32'h03a0_0000, 32'h03a0_0000, 11'd1024, 2'd3, 14'd7000, 1'b1},
    '{P1, 32'h0060_0000, 32'h0060_0000, 11'd1024, 2'd3, 14'd250, 1'b1},
    '{P1, 32'h00a0_0000, 32'h00a0_0000, 11'd1024, 2'd3, 14'd500, 1'b1}};
  int ms[4] = '{100, 200, 500, 1000};
  int errors = 0;
  int tests_run = 0;
  int faults = 0;
  int base;
  logic clock_in = 1'b0, rst_n_in = 1'b0, kick_path = 1'b0;
  logic [15:0] kick_period = 16'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, i2c_kick_in, gpio_kick_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, clock_source_out;
  logic [2:0] ref_clock_rate_sel_out;
  logic [10:0] ref_clock_khz_out;
  logic [13:0] current_cap_ma_out;
  logic ref_clock_input_on_out, spectrum_spreading_out, current_limit_on_out;
  logic watchdog_fault_out, fault_latched_out, power_stage_hiz_out, irq_out;

  clock_watchdog_current_config #(.UNIT_CYCLES(4)) dut_u (.*);
  host_kicker host_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .path_in(kick_path), .period_in(kick_period),
    .i2c_kick_out(i2c_kick_in), .gpio_kick_out(gpio_kick_in));

  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) if (watchdog_fault_out === 1'b1) faults++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bound(inout int n, input int lim);
    n++;
    if (n > lim) begin
      check("wait bound", 0, 1);
      summarize();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw = 1'b1, w = 1'b1;
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    while (aw || w) begin
      @(posedge clock_in);
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      bound(n, 50);
    end
    tick(2);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      bound(n, 50);
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", er, s_axi_bresp);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    do begin
      @(posedge clock_in);
      bound(n, 50);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    tick(2);
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      bound(n, 50);
    end while (s_axi_rvalid !== 1'b1);
    check("rdata", e, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
  endtask
  task automatic wait_fault(input int lo, hi);
    int n = 0;
    do begin
      @(posedge clock_in);
      bound(n, hi);
    end while (watchdog_fault_out !== 1'b1);
    check("timeout early", 1, n >= lo);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(16);
    rst_n_in <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      wr_chk(rows[i].a, rows[i].d, RESP_OKAY);
      rd_chk(rows[i].a, rows[i].rd, RESP_OKAY);
      check("khz", rows[i].khz, ref_clock_khz_out);
      check("source", rows[i].src, clock_source_out);
      check("cap", rows[i].cap, current_cap_ma_out);
      check("limit", rows[i].cap != 0, current_limit_on_out);
      check("spread", rows[i].spread, spectrum_spreading_out);
    end
    rst_n_in <= 1'b0;
    tick(3);
    rst_n_in <= 1'b1;
    tick(1);
    rd_chk(P1, PERI_ONE_RESET, RESP_OKAY);
    rd_chk(S2, 32'h0, RESP_OKAY);
    check("spread reset", 0, spectrum_spreading_out);
    check("cap reset", 0, current_cap_ma_out);
    wr_chk(12'h2a4, 32'hffff_ffff, RESP_SLVERR);
    rd_chk(12'h2a4, 32'h0, RESP_SLVERR);
    // GPIO kicks keep the watchdog quiet; I2C kicks must be ignored.
    wr_chk(IRQ_MASK_ADDR, 32'h7, RESP_OKAY);
    kick_path <= 1'b1;
    kick_period <= 16'd200;
    wr_chk(S2, 32'h13, RESP_OKAY);
    base = faults;
    tick(2000);
    check("gpio soak", base, faults);
    check("kick irq", 1, irq_out);
    kick_path <= 1'b0;
    wait_fault(200, 700);
    tick(2);
    check("hiz", 1, power_stage_hiz_out);
    check("latched", 1, fault_latched_out);
    rd_chk(WDT_STATUS_ADDR, 32'h5, RESP_OKAY);
    rd_chk(IRQ_STATUS_ADDR, 32'h7, RESP_OKAY);
    rd_chk(IRQ_STATUS_ADDR, 32'h0, RESP_OKAY);
    kick_period <= 16'h0;
    wr_chk(S2, 32'h0, RESP_OKAY);
    tick(2);
    check("irq cleared", 0, irq_out);
    check("hiz held", 1, power_stage_hiz_out);
    rd_chk(WDT_CTRL_ADDR, 32'h0, RESP_OKAY);
    wr_chk(WDT_CTRL_ADDR, 32'h1, RESP_OKAY);
    tick(2);
    check("hiz released", 0, power_stage_hiz_out);
    // Every GPIO interval code, with the count restarted by disabling.
    for (int c = 0; c < 4; c++) begin
      wr_chk(S2, 32'h0, RESP_OKAY);
      wr_chk(S2, 32'h12 | (c << 2), RESP_OKAY);
      wait_fault(ms[c] * 4 - 10, ms[c] * 5 + 20);
    end
    // I2C path, report only, with the kick interrupt masked first.
    wr_chk(S2, 32'h0, RESP_OKAY);
    rd_chk(IRQ_STATUS_ADDR, 32'h1, RESP_OKAY);
    wr_chk(IRQ_MASK_ADDR, 32'h0, RESP_OKAY);
    kick_period <= 16'd3000;
    wr_chk(S2, 32'h10, RESP_OKAY);
    base = faults;
    tick(9000);
    check("i2c soak", base, faults);
    check("masked irq", 0, irq_out);
    wr_chk(IRQ_MASK_ADDR, 32'h2, RESP_OKAY);
    tick(2);
    check("unmasked irq", 1, irq_out);
    kick_period <= 16'h0;
    wr_chk(S2, 32'h0, RESP_OKAY);
    wr_chk(S2, 32'h10, RESP_OKAY);
    wait_fault(3990, 5200);
    tick(2);
    check("report hiz", 0, power_stage_hiz_out);
    check("report latch", 0, fault_latched_out);
    summarize();
  end
endmodule  // tb_top

`default_nettype wire
